// File: temp_readout_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the ambient
  temperature readout. Assumes a 40 MHz ref_clk and a two-wire bus host.
*/
`ifndef TEMP_READOUT_CFG_SVH
`define TEMP_READOUT_CFG_SVH

`define AMBIENT_TEMP_PTR 8'h05
`define MAKER_ID_PTR 8'h06
`define AMBIENT_TEMP_RESET 16'h0000
`define CRIT_FLAG_BIT 15
`define UPPER_FLAG_BIT 14
`define LOWER_FLAG_BIT 13
`define SIGN_BIT 12
`define SLAVE_ADDR_DEF 7'h18
// arbitrary neutral identification value
`define MAKER_ID_DEF 16'h5a3c
`define RES_MASK_HALF 13'h1ff8
`define RES_MASK_QUARTER 13'h1ffc
`define RES_MASK_EIGHTH 13'h1ffe
`define RES_MASK_SIXTEENTH 13'h1fff
`define CLK_HZ 40000000
`define CONV_MS_HALF 30
`define CONV_MS_QUARTER 65
`define CONV_MS_EIGHTH 130
`define CONV_MS_SIXTEENTH 250
`define CONV_CYC_HALF (`CONV_MS_HALF * (`CLK_HZ / 1000))
`define CONV_CYC_QUARTER (`CONV_MS_QUARTER * (`CLK_HZ / 1000))
`define CONV_CYC_EIGHTH (`CONV_MS_EIGHTH * (`CLK_HZ / 1000))
`define CONV_CYC_SIXTEENTH (`CONV_MS_SIXTEENTH * (`CLK_HZ / 1000))

`endif

// File: temp_readout_pkg.sv
/*
  Types of the ambient temperature readout.
  Assumes temp_readout_cfg.svh supplies the numbers.
*/
`default_nettype none
package temp_readout_pkg;
  typedef struct packed {
    logic [10:0] critical_limit;
    logic [10:0] upper_limit;
    logic [10:0] lower_limit;
  } limits_t;

  typedef enum logic [1:0] {
    RES_HALF = 2'h0,
    RES_QUARTER = 2'h1,
    RES_EIGHTH = 2'h2,
    RES_SIXTEENTH = 2'h3
  } res_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_PTR = 4'h2,
    ST_PTR_ACK = 4'h6,
    ST_WDAT = 4'h7,
    ST_WDAT_ACK = 4'h5,
    ST_RD = 4'h4,
    ST_RD_ACK = 4'hc
  } bus_state_t;
endpackage : temp_readout_pkg
`default_nettype wire

// File: ambient_temperature_readout.sv
/*
  Ambient temperature register, maker identification register and the
  two-wire slave that reads them. Assumes conv_result comes from the
  converter on ref_clk and that scl/sda arrive asynchronously from pins.
*/
`timescale 1ns/100ps
`default_nettype none
`include "temp_readout_cfg.svh"
module ambient_temperature_readout #(
  parameter logic [6:0] slave_addr = `SLAVE_ADDR_DEF,
  parameter logic [15:0] maker_id = `MAKER_ID_DEF,
  parameter int conv_cycles_half = `CONV_CYC_HALF,
  parameter int conv_cycles_quarter = `CONV_CYC_QUARTER,
  parameter int conv_cycles_eighth = `CONV_CYC_EIGHTH,
  parameter int conv_cycles_sixteenth = `CONV_CYC_SIXTEENTH
)(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic [12:0] conv_result,
  input wire temp_readout_pkg::limits_t limits,
  input wire temp_readout_pkg::res_t resolution,
  output logic [15:0] ambient_temp,
  output logic conv_tick
);
  logic [23:0] conv_cnt;
  logic [12:0] sample;
  logic signed [12:0] crit_ext, upper_ext, lower_ext;
  logic flag_crit, flag_upper, flag_lower;

  function automatic logic [23:0] period_of(input temp_readout_pkg::res_t r);
    case (r)
      temp_readout_pkg::RES_HALF: return 24'(conv_cycles_half - 1);
      temp_readout_pkg::RES_QUARTER: return 24'(conv_cycles_quarter - 1);
      temp_readout_pkg::RES_EIGHTH: return 24'(conv_cycles_eighth - 1);
      default: return 24'(conv_cycles_sixteenth - 1);
    endcase
  endfunction : period_of

  // conversion period timer
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      conv_cnt <= 24'h000000;
      conv_tick <= 1'b0;
    end
    else if (conv_cnt >= period_of(resolution))
    begin
      conv_cnt <= 24'h000000;
      conv_tick <= 1'b1;
    end
    else
    begin
      conv_cnt <= conv_cnt + 24'h000001;
      conv_tick <= 1'b0;
    end
  end

  always_comb
  begin
    unique case (resolution)
      temp_readout_pkg::RES_HALF: sample = conv_result & `RES_MASK_HALF;
      temp_readout_pkg::RES_QUARTER: sample = conv_result & `RES_MASK_QUARTER;
      temp_readout_pkg::RES_EIGHTH: sample = conv_result & `RES_MASK_EIGHTH;
      temp_readout_pkg::RES_SIXTEENTH: sample = conv_result & `RES_MASK_SIXTEENTH;
    endcase
  end

  // limits sit on bits 12:2 of the temperature scale
  assign crit_ext = $signed({limits.critical_limit, 2'b00});
  assign upper_ext = $signed({limits.upper_limit, 2'b00});
  assign lower_ext = $signed({limits.lower_limit, 2'b00});
  // no alert setting reaches these compares
  assign flag_crit = $signed(sample) >= crit_ext;
  assign flag_upper = $signed(sample) > upper_ext;
  assign flag_lower = $signed(sample) < lower_ext;

  // one parallel load of flags and data
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      ambient_temp <= `AMBIENT_TEMP_RESET;
    else if (conv_tick)
      ambient_temp <= {flag_crit, flag_upper, flag_lower, sample};
  end

  // pin synchronisers
  logic [2:0] scl_s, sda_s;
  logic scl_q, sda_q, scl_d, sda_d;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      scl_q <= (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_q;
      sda_q <= (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_q;
      scl_d <= scl_q;
      sda_d <= sda_q;
    end
  end

  assign scl_rise = scl_q & ~scl_d;
  assign scl_fall = ~scl_q & scl_d;
  assign bus_start = scl_q & scl_d & sda_d & ~sda_q;
  assign bus_stop = scl_q & scl_d & ~sda_d & sda_q;

  temp_readout_pkg::bus_state_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg, pointer, tx_byte;
  logic [15:0] rd_word, reg_value;
  logic read_dir, host_nack;

  always_comb
  begin
    if (pointer == `AMBIENT_TEMP_PTR)
      reg_value = ambient_temp;
    else if (pointer == `MAKER_ID_PTR)
      reg_value = maker_id;
    else
      reg_value = 16'h0000;
  end

  assign sda_o = 1'b0;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= temp_readout_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      pointer <= 8'h00;
      tx_byte <= 8'h00;
      rd_word <= 16'h0000;
      read_dir <= 1'b0;
      host_nack <= 1'b0;
      sda_oe <= 1'b0;
    end
    else if (bus_start)
    begin
      state <= temp_readout_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe <= 1'b0;
    end
    else if (bus_stop)
    begin
      state <= temp_readout_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end
    else if (scl_rise)
    begin
      shreg <= {shreg[6:0], sda_q};
      bit_cnt <= bit_cnt + 4'h1;
      if (state == temp_readout_pkg::ST_RD_ACK)
        host_nack <= sda_q;
    end
    else if (scl_fall)
    begin
      unique case (state)
        temp_readout_pkg::ST_ADDR:
          if (bit_cnt == 4'h8)
          begin
            if (shreg[7:1] == slave_addr)
            begin
              state <= temp_readout_pkg::ST_ADDR_ACK;
              read_dir <= shreg[0];
              rd_word <= reg_value;
              sda_oe <= 1'b1;
            end
            else
              state <= temp_readout_pkg::ST_IDLE;
          end
        temp_readout_pkg::ST_ADDR_ACK:
        begin
          bit_cnt <= 4'h0;
          if (read_dir)
          begin
            state <= temp_readout_pkg::ST_RD;
            tx_byte <= {rd_word[14:8], 1'b0};
            sda_oe <= ~rd_word[15];
          end
          else
          begin
            state <= temp_readout_pkg::ST_PTR;
            sda_oe <= 1'b0;
          end
        end
        temp_readout_pkg::ST_PTR:
          if (bit_cnt == 4'h8)
          begin
            state <= temp_readout_pkg::ST_PTR_ACK;
            pointer <= shreg;
            sda_oe <= 1'b1;
          end
        temp_readout_pkg::ST_WDAT:
          if (bit_cnt == 4'h8)
          begin
            state <= temp_readout_pkg::ST_WDAT_ACK; // data dropped
            sda_oe <= 1'b1;
          end
        temp_readout_pkg::ST_PTR_ACK, temp_readout_pkg::ST_WDAT_ACK:
        begin
          state <= temp_readout_pkg::ST_WDAT;
          bit_cnt <= 4'h0;
          sda_oe <= 1'b0;
        end
        temp_readout_pkg::ST_RD:
          if (bit_cnt == 4'h8)
          begin
            state <= temp_readout_pkg::ST_RD_ACK;
            sda_oe <= 1'b0;
          end
          else
          begin
            sda_oe <= ~tx_byte[7];
            tx_byte <= {tx_byte[6:0], 1'b0};
          end
        temp_readout_pkg::ST_RD_ACK:
          if (host_nack)
            state <= temp_readout_pkg::ST_IDLE;
          else
          begin
            // upper byte then lower byte
            state <= temp_readout_pkg::ST_RD;
            bit_cnt <= 4'h0;
            rd_word <= {rd_word[7:0], rd_word[15:8]};
            tx_byte <= {rd_word[6:0], 1'b0};
            sda_oe <= ~rd_word[7];
          end
        temp_readout_pkg::ST_IDLE:
          sda_oe <= 1'b0;
      endcase
    end
  end

  sequence load_s;
    conv_tick;
  endsequence

  sequence addr_match_s;
    scl_fall && state == temp_readout_pkg::ST_ADDR && bit_cnt == 4'h8
      && shreg[7:1] == slave_addr;
  endsequence

  crit_flag_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    load_s |=> ambient_temp[15] == $past(flag_crit))
    else $error("critical flag not loaded");
  upper_flag_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    load_s |=> ambient_temp[14] == ($signed($past(sample)) > $past(upper_ext)))
    else $error("upper flag wrong");
  lower_flag_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    load_s |=> ambient_temp[13] == ($signed($past(sample)) < $past(lower_ext)))
    else $error("lower flag wrong");
  temp_data_load_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    load_s |=> ambient_temp[12:0] == $past(sample))
    else $error("temperature data not loaded");
  temp_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !conv_tick |=> $stable(ambient_temp))
    else $error("temperature changed between loads");
  quarter_mask_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    load_s and resolution == temp_readout_pkg::RES_QUARTER |=> ambient_temp[1:0] == 2'h0)
    else $error("unused resolution bits set");
  maker_read_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    addr_match_s and pointer == `MAKER_ID_PTR |=> rd_word == maker_id)
    else $error("maker id not returned");
  addr_ack_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    addr_match_s |=> sda_oe && state == temp_readout_pkg::ST_ADDR_ACK)
    else $error("address not acknowledged");
  write_ignored_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    state == temp_readout_pkg::ST_WDAT && !conv_tick
      |=> $stable(ambient_temp) && $stable(pointer))
    else $error("write altered read-only data");
endmodule : ambient_temperature_readout
`default_nettype wire

// File: i2c_host_model.sv
/*
  two-wire bus host model that reads and writes sensor registers.
  assumes an open-drain data wire with a pull-up, resolved by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model #(
  parameter int half = 10
)(
  input wire logic ref_clk,
  input wire logic sda,
  output var logic scl,
  output var logic pull
);
  initial
  begin
    scl = 1'b1;
    pull = 1'b0;
  end

  task hw;
    repeat (half) @(posedge ref_clk);
    #1;
  endtask : hw

  // data changes only while scl is low
  task bit_io(input logic b, output logic r);
    hw();
    pull = ~b;
    hw();
    scl = 1'b1;
    hw();
    r = sda;
    scl = 1'b0;
  endtask : bit_io

  task start;
    hw();
    pull = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    pull = 1'b1;
    hw();
    scl = 1'b0;
  endtask : start

  task stop;
    hw();
    pull = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    pull = 1'b0;
    hw();
  endtask : stop

  task put(input logic [7:0] v, inout logic nak);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(v[i], r);
    bit_io(1'b1, r);
    nak = nak | r;
  endtask : put

  task get(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, v[i]);
    bit_io(last, r);
  endtask : get

  task read_reg(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d,
                output logic nak);
    nak = 1'b0;
    start();
    put({a, 1'b0}, nak);
    put(p, nak);
    start();
    put({a, 1'b1}, nak);
    get(1'b0, d[15:8]);
    get(1'b1, d[7:0]);
    stop();
  endtask : read_reg

  task write_reg(input logic [6:0] a, input logic [7:0] p, input logic [15:0] w,
                 output logic nak);
    nak = 1'b0;
    start();
    put({a, 1'b0}, nak);
    put(p, nak);
    put(w[15:8], nak);
    put(w[7:0], nak);
    stop();
  endtask : write_reg
endmodule : i2c_host_model
`default_nettype wire

// File: tb_ambient_temperature_readout.sv
/*
  self-checking bench of the temperature readout.
  assumes the host model drives the bus and a 40 MHz ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_ambient_temperature_readout;
  localparam logic [6:0] addr = 7'h18;
  // arbitrary identification value
  localparam logic [15:0] id = 16'h3c96;
  localparam int per[4] = '{40, 50, 60, 70};
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [12:0] conv_result = 13'h0000;
  temp_readout_pkg::limits_t limits = '0;
  temp_readout_pkg::res_t resolution = temp_readout_pkg::RES_HALF;
  logic scl, pull, sda, sda_o, sda_oe, conv_tick, nak;
  logic [15:0] ambient_temp, d;
  int n_mismatch = 0;
  int compares = 0;
  longint t0;
  // sample, critical, upper, lower, resolution
  logic [47:0] cases[4] = '{
    {13'h0194, 11'h065, 11'h065, 11'h066, 2'h1},
    {13'h1f8f, 11'h7ff, 11'h7e0, 11'h7e0, 2'h3},
    {13'h0a57, 11'h000, 11'h000, 11'h000, 2'h0},
    {13'h1001, 11'h400, 11'h3ff, 11'h401, 2'h2}};

  assign sda = ~((sda_oe & ~sda_o) | pull);

  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  ambient_temperature_readout #(.slave_addr(addr), .maker_id(id),
    .conv_cycles_half(40), .conv_cycles_quarter(50),
    .conv_cycles_eighth(60), .conv_cycles_sixteenth(70)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .conv_result(conv_result),
    .limits(limits), .resolution(resolution),
    .ambient_temp(ambient_temp), .conv_tick(conv_tick));

  i2c_host_model #(.half(10)) host (
    .ref_clk(ref_clk), .sda(sda), .scl(scl), .pull(pull));

  function automatic logic [15:0] exp_temp(input logic [47:0] c);
    logic [12:0] m;
    temp_readout_pkg::limits_t l;
    m = c[47:35] & ~(13'h0007 >> c[1:0]);
    l = c[34:2];
    return {$signed(m) >= $signed({l.critical_limit, 2'b00}),
            $signed(m) > $signed({l.upper_limit, 2'b00}),
            $signed(m) < $signed({l.lower_limit, 2'b00}), m};
  endfunction : exp_temp

  // host conversion in sixteenths of a degree, flags and sign masked off
  function automatic logic [15:0] to_sixteenths(input logic [15:0] w);
    logic [15:0] v;
    v = {w[15:8] & 8'h0f, w[7:0]};
    if (w[12])
      return 16'h1000 - v;
    return v;
  endfunction : to_sixteenths

  task stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  task chk(input string name, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, e, s);
    end
  endtask : chk

  task wait_tick;
    int i;
    i = 0;
    do
    begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    while (conv_tick !== 1'b1 && i < 1000);
    if (conv_tick !== 1'b1)
    begin
      n_mismatch++;
      $display("mismatch conv_tick expected 1 seen %b", conv_tick);
      stop_test();
    end
  endtask : wait_tick

  initial
  begin
    repeat (16) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    chk("ambient_temp", 16'h0000, ambient_temp);
    for (int c = 0; c < 4; c++)
    begin
      conv_result = cases[c][47:35];
      limits = cases[c][34:2];
      resolution = temp_readout_pkg::res_t'(cases[c][1:0]);
      wait_tick();
      wait_tick();
      t0 = $time;
      wait_tick();
      chk("period", 16'(per[cases[c][1:0]]), 16'(($time - t0) / 25));
      @(posedge ref_clk);
      #1;
      chk("ambient_temp", exp_temp(cases[c]), ambient_temp);
    end
    host.read_reg(addr, 8'h05, d, nak);
    chk("temp_read", exp_temp(cases[3]), d);
    chk("degrees16", 16'h1000, to_sixteenths(d));
    chk("ack", 16'h0000, {15'h0000, nak});
    host.write_reg(addr, 8'h05, 16'h0000, nak);
    host.write_reg(addr, 8'h06, 16'h0000, nak);
    host.read_reg(addr, 8'h05, d, nak);
    chk("temp_after_write", exp_temp(cases[3]), d);
    host.read_reg(addr, 8'h06, d, nak);
    chk("maker_id", id, d);
    host.read_reg(addr, 8'h07, d, nak);
    chk("unmapped", 16'h0000, d);
    host.read_reg(7'h19, 8'h05, d, nak);
    chk("foreign_nak", 16'h0001, {15'h0000, nak});
    stop_test();
  end
endmodule : tb_ambient_temperature_readout
`default_nettype wire
